// File: inc/uart_pkg.sv
// Shared constants and types for the UART line and FIFO control block
package uart_pkg;
  localparam int ADDR_W = 12;
  localparam logic [6:0] DEPTH = 7'h40;
  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_ONE = 3'h1;
  localparam logic [2:0] IDX_FIFO = 3'h2;
  localparam logic [2:0] IDX_LINE = 3'h3;
  localparam logic [2:0] IDX_MODEM = 3'h4;
  localparam logic [2:0] IDX_LSTAT = 3'h5;
  localparam logic [2:0] IDX_MSTAT = 3'h6;
  localparam logic [2:0] IDX_SEVEN = 3'h7;
  // Field positions
  localparam int FC_EN = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_DMA = 3;
  localparam int FC_TXTRIG = 4;
  localparam int FC_RXTRIG = 6;
  localparam int LF_STOP = 2;
  localparam int LF_PEN = 3;
  localparam int LF_EVEN = 4;
  localparam int LF_FORCE = 5;
  localparam int LF_BREAK = 6;
  localparam int LF_DLAB = 7;
  localparam int MO_TREADY = 0;
  localparam int MO_SREQ = 1;
  localparam int MO_AUX1 = 2;
  localparam int MO_LOOP = 4;
  localparam int MO_TRIGEN = 6;
  localparam int EF_ENH = 4;
  localparam int EF_AUTOSR = 6;
  localparam int FT_HALFDUP = 3;
  // Reset values and key
  localparam logic [7:0] LINE_RESET = 8'h05;
  localparam logic [7:0] MODEM_RESET = 8'h00;
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] LINE_KEY = 8'hBF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Timing in 16x sample ticks
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h07;
  localparam logic [5:0] STOP_ONE = 6'h10;
  localparam logic [5:0] STOP_ONE_HALF = 6'h18;
  localparam logic [5:0] STOP_TWO = 6'h20;
  localparam int TIMEOUT_BITS = 52;
  localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_BITS * 16);

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_in_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_out_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b010,
    S_PAR = 3'b011,
    S_STOP = 3'b100
  } frame_state_t;
endpackage

// File: core/uart_line_fifo_control.sv
// UART channel: line format, FIFO control, modem outputs, AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module uart_line_fifo_control (
  input wire logic mclk,
  input wire logic rst_n,
  input wire uart_pkg::axil_in_t bus_in,
  output uart_pkg::axil_out_t bus_out,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic ring_indicator_in,
  output logic terminal_ready_n,
  output logic send_request_n,
  output logic tx_request_pin,
  output logic rx_request_pin,
  output logic tx_int,
  output logic rx_int
);
  import uart_pkg::*;

  function automatic logic [6:0] tx_level(input logic [1:0] sel);
    case (sel)
      2'b00: tx_level = 7'h08;
      2'b01: tx_level = 7'h10;
      2'b10: tx_level = 7'h20;
      default: tx_level = 7'h38;
    endcase
  endfunction

  function automatic logic [6:0] rx_level(input logic [1:0] sel);
    case (sel)
      2'b00: rx_level = 7'h08;
      2'b01: rx_level = 7'h10;
      2'b10: rx_level = 7'h38;
      default: rx_level = 7'h3C;
    endcase
  endfunction

  function automatic logic parity_of(input logic [7:0] d, input logic [7:0] lf);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - lf[1:0]));
    if (lf[LF_FORCE])
      parity_of = ~lf[LF_EVEN];
    else
      parity_of = (^m) ^ ~lf[LF_EVEN];
  endfunction

  logic [7:0] line_format_reg, modem_output_reg, enhanced_feature_reg;
  logic [7:0] feature_control_reg, scratch_reg, trigger_level_reg;
  logic [7:0] divisor_low, divisor_high_byte, divisor_fraction;
  logic fifo_en, dma_mode;
  logic [1:0] tx_trig_sel, rx_trig_sel;
  axil_out_t bus_q;

  // Bus decode
  wire aw_hs = bus_in.awvalid & bus_q.awready;
  wire ar_hs = bus_in.arvalid & bus_q.arready;
  wire w_ok = bus_in.awaddr[ADDR_W-1:5] == '0;
  wire r_ok = bus_in.araddr[ADDR_W-1:5] == '0;
  wire [2:0] widx = bus_in.awaddr[4:2];
  wire [2:0] ridx = bus_in.araddr[4:2];
  wire wr = aw_hs & w_ok & bus_in.wstrb[0];
  wire [7:0] wd = bus_in.wdata[7:0];
  wire key = line_format_reg == LINE_KEY;
  wire dlab = line_format_reg[LF_DLAB];
  wire enh = enhanced_feature_reg[EF_ENH];
  wire loop = modem_output_reg[MO_LOOP];
  wire sel_ready = ~loop & modem_output_reg[MO_AUX1];
  wire sel_trig = ~sel_ready & enh & modem_output_reg[MO_TRIGEN];
  wire wr_tx = wr & widx == IDX_DATA & ~dlab;
  wire wr_dll = wr & widx == IDX_DATA & dlab;
  wire wr_div_high = wr & widx == IDX_ONE & dlab & ~key;
  wire wr_feat_ctl = wr & widx == IDX_ONE & key;
  wire wr_enh = wr & widx == IDX_FIFO & key;
  wire wr_div_frac = wr & widx == IDX_FIFO & dlab & ~key;
  wire wr_fifo_ctl = wr & widx == IDX_FIFO & ~dlab;
  wire wr_line = wr & widx == IDX_LINE;
  wire wr_modem = wr & widx == IDX_MODEM;
  wire wr_seven = wr & widx == IDX_SEVEN & ~sel_ready;
  wire rx_flush = wr_fifo_ctl & wd[FC_EN] & wd[FC_RXRST];
  wire tx_flush = wr_fifo_ctl & wd[FC_EN] & wd[FC_TXRST];

  // Control registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_format_reg <= LINE_RESET;
      modem_output_reg <= MODEM_RESET;
      enhanced_feature_reg <= ZERO_RESET;
      feature_control_reg <= ZERO_RESET;
      scratch_reg <= ZERO_RESET;
      trigger_level_reg <= ZERO_RESET;
      divisor_low <= DIV_LOW_RESET;
      divisor_high_byte <= ZERO_RESET;
      divisor_fraction <= ZERO_RESET;
    end
    else
    begin
      if (wr_line) line_format_reg <= wd;
      if (wr_modem)
        modem_output_reg <= {enh ? wd[7:5] : modem_output_reg[7:5], wd[4:0]};
      if (wr_enh) enhanced_feature_reg <= wd;
      if (wr_feat_ctl) feature_control_reg <= wd;
      if (wr_seven & sel_trig) trigger_level_reg <= wd;
      if (wr_seven & ~sel_trig) scratch_reg <= wd;
      if (wr_dll) divisor_low <= wd;
      if (wr_div_high) divisor_high_byte <= wd;
      if (wr_div_frac) divisor_fraction <= wd;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_en <= 1'b0;
      dma_mode <= 1'b0;
      tx_trig_sel <= 2'b00;
      rx_trig_sel <= 2'b00;
    end
    else if (wr_fifo_ctl)
    begin
      fifo_en <= wd[FC_EN];
      if (wd[FC_EN])
      begin
        dma_mode <= wd[FC_DMA];
        rx_trig_sel <= wd[FC_RXTRIG+:2];
        if (enh) tx_trig_sel <= wd[FC_TXTRIG+:2];
      end
    end
  end

  // Baud tick at sixteen times the bit rate
  logic [15:0] baud_cnt;
  wire [15:0] divisor = {divisor_high_byte, divisor_low};
  wire tick = divisor != 16'h0000 & baud_cnt == divisor - 16'h0001;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) baud_cnt <= 16'h0000;
    else baud_cnt <= tick | divisor == 16'h0000 ? 16'h0000 : baud_cnt + 16'h0001;
  end

  // Transmit FIFO
  logic [7:0] tx_mem [0:63];
  logic [5:0] tx_wp, tx_rp;
  logic [6:0] tx_cnt;
  logic tx_pop;
  wire tx_push = wr_tx & tx_cnt != DEPTH;
  always_ff @(posedge mclk)
  begin
    if (tx_push) tx_mem[tx_wp] <= wd;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp <= 6'h00;
      tx_rp <= 6'h00;
      tx_cnt <= 7'h00;
    end
    else if (tx_flush)
    begin
      tx_wp <= 6'h00;
      tx_rp <= 6'h00;
      tx_cnt <= 7'h00;
    end
    else
    begin
      tx_wp <= tx_wp + 6'(tx_push);
      tx_rp <= tx_rp + 6'(tx_pop);
      tx_cnt <= tx_cnt + 7'(tx_push) - 7'(tx_pop);
    end
  end

  // Transmitter
  frame_state_t tx_state;
  logic [7:0] tsr;
  logic [2:0] tx_bit;
  logic [5:0] tx_sub;
  wire [2:0] last_bit = 3'h4 + {1'b0, line_format_reg[1:0]};
  wire [5:0] stop_len = !line_format_reg[LF_STOP] ? STOP_ONE :
    line_format_reg[1:0] == 2'b00 ? STOP_ONE_HALF : STOP_TWO;
  wire tx_bit_end = tick & tx_sub == TICKS_BIT - 6'h01;
  assign tx_pop = tx_state == S_IDLE & tx_cnt != 7'h00 & ~tx_flush;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state <= S_IDLE;
      tsr <= 8'h00;
      tx_bit <= 3'h0;
      tx_sub <= 6'h00;
    end
    else
    begin
      if (tick) tx_sub <= tx_sub + 6'h01;
      case (tx_state)
        S_IDLE:
          if (tx_pop)
          begin
            tsr <= tx_mem[tx_rp];
            tx_sub <= 6'h00;
            tx_state <= S_START;
          end
        S_START:
          if (tx_bit_end)
          begin
            tx_sub <= 6'h00;
            tx_bit <= 3'h0;
            tx_state <= S_DATA;
          end
        S_DATA:
          if (tx_bit_end)
          begin
            tx_sub <= 6'h00;
            tx_bit <= tx_bit + 3'h1;
            tsr <= {1'b0, tsr[7:1]};
            if (tx_bit == last_bit)
              tx_state <= line_format_reg[LF_PEN] ? S_PAR : S_STOP;
          end
        S_PAR:
          if (tx_bit_end)
          begin
            tx_sub <= 6'h00;
            tx_state <= S_STOP;
          end
        S_STOP:
          if (tick & tx_sub == stop_len - 6'h01)
            tx_state <= S_IDLE;
        default: tx_state <= S_IDLE;
      endcase
    end
  end

  logic [7:0] tx_char;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) tx_char <= 8'h00;
    else if (tx_pop) tx_char <= tx_mem[tx_rp];
  end
  wire tx_par = parity_of(tx_char, line_format_reg);
  wire line_bit = tx_state == S_START ? 1'b0 :
    tx_state == S_DATA ? tsr[0] : tx_state == S_PAR ? tx_par : 1'b1;
  wire tx_line = line_format_reg[LF_BREAK] ? 1'b0 : line_bit;

  // Pin synchronisers
  logic [1:0] rx_sync, ring_sync;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sync <= 2'b11;
      ring_sync <= 2'b11;
    end
    else
    begin
      rx_sync <= {rx_sync[0], serial_in};
      ring_sync <= {ring_sync[0], ring_indicator_in};
    end
  end
  wire rx_line = loop ? tx_line : rx_sync[1];
  wire ring_state = loop ? modem_output_reg[MO_AUX1] : ~ring_sync[1];

  // Receive FIFO holds framing error, parity error and data
  logic [9:0] rx_mem [0:63];
  logic [5:0] rx_wp, rx_rp;
  logic [6:0] rx_cnt;
  logic rx_done, rx_pe, rx_fe, overrun, rx_timeout;
  logic [7:0] rsr;
  wire rx_pop = ar_hs & r_ok & ridx == IDX_DATA & ~dlab & rx_cnt != 7'h00;
  wire rx_push = rx_done & rx_cnt != DEPTH;
  wire [7:0] rx_char = rsr >> (2'h3 - line_format_reg[1:0]);
  always_ff @(posedge mclk)
  begin
    if (rx_push) rx_mem[rx_wp] <= {rx_fe, rx_pe, rx_char};
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_wp <= 6'h00;
      rx_rp <= 6'h00;
      rx_cnt <= 7'h00;
    end
    else if (rx_flush)
    begin
      rx_wp <= 6'h00;
      rx_rp <= 6'h00;
      rx_cnt <= 7'h00;
    end
    else
    begin
      rx_wp <= rx_wp + 6'(rx_push);
      rx_rp <= rx_rp + 6'(rx_pop);
      rx_cnt <= rx_cnt + 7'(rx_push) - 7'(rx_pop);
    end
  end

  // Receiver, samples mid-bit
  frame_state_t rx_state;
  logic [2:0] rx_bit;
  logic [5:0] rx_sub;
  wire rx_mid = tick & rx_sub == TICKS_BIT - 6'h01;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state <= S_IDLE;
      rsr <= 8'h00;
      rx_bit <= 3'h0;
      rx_sub <= 6'h00;
      rx_pe <= 1'b0;
      rx_fe <= 1'b0;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (tick) rx_sub <= rx_sub + 6'h01;
      case (rx_state)
        S_IDLE:
          if (tick & ~rx_line)
          begin
            rx_sub <= 6'h00;
            rx_state <= S_START;
          end
        S_START:
          if (tick & rx_sub == TICKS_HALF)
          begin
            rx_sub <= 6'h00;
            rx_bit <= 3'h0;
            rx_pe <= 1'b0;
            rx_state <= rx_line ? S_IDLE : S_DATA;
          end
        S_DATA:
          if (rx_mid)
          begin
            rx_sub <= 6'h00;
            rx_bit <= rx_bit + 3'h1;
            rsr <= {rx_line, rsr[7:1]};
            if (rx_bit == last_bit)
              rx_state <= line_format_reg[LF_PEN] ? S_PAR : S_STOP;
          end
        S_PAR:
          if (rx_mid)
          begin
            rx_sub <= 6'h00;
            rx_pe <= rx_line != parity_of(rx_char, line_format_reg);
            rx_state <= S_STOP;
          end
        S_STOP:
          if (rx_mid)
          begin
            rx_fe <= ~rx_line;
            rx_done <= 1'b1;
            rx_state <= S_IDLE;
          end
        default: rx_state <= S_IDLE;
      endcase
    end
  end

  // Overrun and receive timeout
  logic [9:0] idle_ticks;
  wire lstat_rd = ar_hs & r_ok & ridx == IDX_LSTAT;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun <= 1'b0;
      idle_ticks <= 10'h000;
      rx_timeout <= 1'b0;
    end
    else
    begin
      if (rx_done & rx_cnt == DEPTH) overrun <= 1'b1;
      else if (lstat_rd) overrun <= 1'b0;
      if (rx_push | rx_pop | rx_cnt == 7'h00 | rx_state != S_IDLE)
        idle_ticks <= 10'h000;
      else if (tick & idle_ticks != TIMEOUT_TICKS)
        idle_ticks <= idle_ticks + 10'h001;
      if (tick & idle_ticks == TIMEOUT_TICKS - 10'h001) rx_timeout <= 1'b1;
      else if (rx_pop | rx_flush) rx_timeout <= 1'b0;
    end
  end

  // Trigger levels, interrupts and request pins
  wire [6:0] tx_trig = fifo_en & enh ? tx_level(tx_trig_sel) : 7'h01;
  wire [6:0] rx_trig = fifo_en ? rx_level(rx_trig_sel) : 7'h01;
  wire [6:0] tx_space = DEPTH - tx_cnt;
  wire tx_cond = tx_space > tx_trig | tx_cnt == 7'h00;
  wire rx_cond = rx_cnt > rx_trig | rx_timeout;
  wire tx_busy = tx_state != S_IDLE;
  wire auto_flow = enhanced_feature_reg[EF_AUTOSR];
  wire half_dup = feature_control_reg[FT_HALFDUP];
  wire next_send_n = loop ? 1'b1 :
    half_dup ? ~(tx_busy | tx_cnt != 7'h00) :
    auto_flow ? rx_cnt >= rx_trig : ~modem_output_reg[MO_SREQ];
  wire next_tx_req_n = dma_mode ? ~tx_cond : tx_cnt != 7'h00;
  wire next_rx_req_n = dma_mode ? ~rx_cond : rx_cnt == 7'h00;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_out <= 1'b1;
      terminal_ready_n <= 1'b1;
      send_request_n <= 1'b1;
      tx_request_pin <= 1'b1;
      rx_request_pin <= 1'b1;
      tx_int <= 1'b0;
      rx_int <= 1'b0;
    end
    else
    begin
      serial_out <= loop ? 1'b1 : tx_line;
      terminal_ready_n <= loop | ~modem_output_reg[MO_TREADY];
      send_request_n <= next_send_n;
      tx_request_pin <= next_tx_req_n;
      rx_request_pin <= next_rx_req_n;
      tx_int <= tx_cond;
      rx_int <= rx_cond;
    end
  end

  // Read multiplexer
  wire [9:0] rx_head = rx_mem[rx_rp];
  wire rx_any = rx_cnt != 7'h00;
  wire [7:0] line_status = {1'b0, ~tx_busy & tx_cnt == 7'h00, tx_cnt == 7'h00,
    1'b0, rx_any & rx_head[9], rx_any & rx_head[8], overrun, rx_any};
  wire [7:0] fifo_ready = {3'b000, next_rx_req_n, 3'b000, next_tx_req_n};
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    case (ridx)
      IDX_DATA: rd_byte = dlab ? divisor_low : rx_any ? rx_head[7:0] : 8'h00;
      IDX_ONE: rd_byte = key ? feature_control_reg : dlab ? divisor_high_byte : 8'h00;
      IDX_FIFO: rd_byte = key ? enhanced_feature_reg : dlab ? divisor_fraction :
        {fifo_en, fifo_en, 6'h00};
      IDX_LINE: rd_byte = line_format_reg;
      IDX_MODEM: rd_byte = modem_output_reg;
      IDX_LSTAT: rd_byte = line_status;
      IDX_MSTAT: rd_byte = {1'b0, ring_state, 6'h00};
      IDX_SEVEN: rd_byte = sel_ready ? fifo_ready : sel_trig ? trigger_level_reg :
        scratch_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // AXI4-Lite slave handshakes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) bus_q <= '0;
    else
    begin
      bus_q.awready <= bus_in.awvalid & bus_in.wvalid & ~bus_q.awready & ~bus_q.bvalid;
      bus_q.wready <= bus_in.awvalid & bus_in.wvalid & ~bus_q.awready & ~bus_q.bvalid;
      if (aw_hs)
      begin
        bus_q.bvalid <= 1'b1;
        bus_q.bresp <= w_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (bus_in.bready) bus_q.bvalid <= 1'b0;
      bus_q.arready <= bus_in.arvalid & ~bus_q.arready & ~bus_q.rvalid;
      if (ar_hs)
      begin
        bus_q.rvalid <= 1'b1;
        bus_q.rdata <= r_ok ? {24'h000000, rd_byte} : 32'h00000000;
        bus_q.rresp <= r_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (bus_in.rready) bus_q.rvalid <= 1'b0;
    end
  end
  assign bus_out = bus_q;
endmodule // uart_line_fifo_control

// File: bench/uart_line_fifo_control_assertions.sv
// Port checker for the UART line and FIFO control block
`timescale 1ns/1ps
module uart_line_fifo_control_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire uart_pkg::axil_in_t bus_in,
  input wire uart_pkg::axil_out_t bus_out,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic ring_indicator_in,
  input wire logic terminal_ready_n,
  input wire logic send_request_n,
  input wire logic tx_request_pin,
  input wire logic rx_request_pin,
  input wire logic tx_int,
  input wire logic rx_int
);
  import uart_pkg::*;
  logic [7:0] line_q;
  logic [4:0] modem_q;
  logic [7:0] feat_q;
  logic fct_q;
  logic fen;
  logic dma;
  wire aw_hs = bus_in.awvalid && bus_out.awready;
  wire wt = aw_hs && bus_in.wstrb[0] && bus_in.awaddr[11:5] == 7'h00;
  wire [2:0] ix = bus_in.awaddr[4:2];
  wire [7:0] wd = bus_in.wdata[7:0];
  wire key = line_q == LINE_KEY;
  wire fc_wr = wt && ix == IDX_FIFO && !key && !line_q[LF_DLAB];
  wire brk = line_q[LF_BREAK] && !modem_q[MO_LOOP];
  wire lp = modem_q[MO_LOOP] && !line_q[LF_BREAK];
  // Shadow of the control registers, updated at the write handshake
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      line_q <= LINE_RESET;
      modem_q <= 5'h00;
      feat_q <= ZERO_RESET;
      fct_q <= 1'b0;
      fen <= 1'b0;
      dma <= 1'b0;
    end
    else if (wt)
    begin
      if (ix == IDX_LINE) line_q <= wd;
      if (ix == IDX_MODEM) modem_q <= wd[4:0];
      if (ix == IDX_FIFO && key) feat_q <= wd;
      if (ix == IDX_ONE && key) fct_q <= wd[FT_HALFDUP];
      if (fc_wr) fen <= wd[FC_EN];
      if (fc_wr && wd[FC_EN]) dma <= wd[FC_DMA];
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_break; brk [*2] |-> !serial_out; endproperty
  a_break: assert property (p_break) else $error("break not on line");
  property p_loop; lp [*2] |-> serial_out && terminal_ready_n && send_request_n; endproperty
  a_loop: assert property (p_loop) else $error("loopback pins wrong");
  property p_dtr; $stable(modem_q) && !modem_q[MO_LOOP]
    |-> terminal_ready_n == !modem_q[MO_TREADY];
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready pin wrong");
  property p_rts; $stable(modem_q) && !modem_q[MO_LOOP] && !feat_q[EF_AUTOSR] && !fct_q
    |-> send_request_n == !modem_q[MO_SREQ]; endproperty
  a_rts: assert property (p_rts) else $error("send request pin wrong");
  property p_dma; fen && dma && $stable({fen, dma}) |-> tx_request_pin == !tx_int; endproperty
  a_dma: assert property (p_dma) else $error("dma request pin wrong");
  property p_txrst; fc_wr && wd[FC_EN] && wd[FC_TXRST] |-> ##2 tx_int; endproperty
  a_txrst: assert property (p_txrst) else $error("tx flush left data");
  property p_rxrst; fc_wr && wd[FC_EN] && wd[FC_RXRST] |-> ##2 !rx_int && rx_request_pin;
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("rx flush left data");
  property p_decerr; aw_hs && bus_in.awaddr[11:5] != 7'h00
    |=> bus_out.bvalid && bus_out.bresp == RESP_DECERR; endproperty
  a_decerr: assert property (p_decerr) else $error("bad address accepted");
  property p_rack; bus_in.arvalid && bus_out.arready |=> bus_out.rvalid && !bus_out.arready;
  endproperty
  a_rack: assert property (p_rack) else $error("read answer late");
endmodule // uart_line_fifo_control_checker

bind uart_line_fifo_control uart_line_fifo_control_checker u_checker (
  .mclk(mclk), .rst_n(rst_n), .bus_in(bus_in), .bus_out(bus_out), .serial_in(serial_in),
  .serial_out(serial_out), .ring_indicator_in(ring_indicator_in),
  .terminal_ready_n(terminal_ready_n), .send_request_n(send_request_n),
  .tx_request_pin(tx_request_pin), .rx_request_pin(rx_request_pin), .tx_int(tx_int),
  .rx_int(rx_int)
);

// File: bench/serial_peer.sv
// Remote serial device: captures and sends frames at a fixed bit time
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 16
) (
  input wire logic mclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  task automatic grab(output logic [11:0] f);
    while (tx_line !== 1'b0) @(posedge mclk);
    repeat (BIT / 2) @(posedge mclk);
    for (int k = 0; k < 12; k++)
    begin
      f[k] = tx_line;
      repeat (BIT) @(posedge mclk);
    end
  endtask
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      @(posedge mclk);
      rx_line <= f[k];
      repeat (BIT - 1) @(posedge mclk);
    end
  endtask
endmodule // serial_peer

// File: bench/tb_top.sv
// Testbench for the UART line and FIFO control block
`timescale 1ns/1ps
module tb_top;
  import uart_pkg::*;
  logic mclk;
  logic rst_n;
  axil_in_t bi;
  axil_out_t bo;
  logic ser_in, ser_out, ring_n, dtr_n, rts_n, txq, rxq, txi, rxi;
  logic [6:0] hi;
  logic [1:0] resp;
  logic [11:0] fr;
  int n_fail;
  int total_checks;
  logic [7:0] fl [3] = '{8'h1B, 8'h28, 8'h0A};
  logic [7:0] fd [3] = '{8'hA5, 8'h13, 8'h55};
  uart_line_fifo_control u_uart_line_fifo_control (
    .mclk(mclk), .rst_n(rst_n), .bus_in(bi), .bus_out(bo), .serial_in(ser_in),
    .serial_out(ser_out), .ring_indicator_in(ring_n), .terminal_ready_n(dtr_n),
    .send_request_n(rts_n), .tx_request_pin(txq), .rx_request_pin(rxq), .tx_int(txi),
    .rx_int(rxi)
  );
  serial_peer u_serial_peer (.mclk(mclk), .tx_line(ser_out), .rx_line(ser_in));
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    bi.awaddr <= {hi, i, 2'b00};
    bi.wdata <= {24'h000000, d};
    bi.awvalid <= 1'b1;
    bi.wvalid <= 1'b1;
    bi.bready <= 1'b1;
    do @(posedge mclk); while (bo.awready !== 1'b1 && ++t < 99);
    bi.awvalid <= 1'b0;
    bi.wvalid <= 1'b0;
    while (bo.bvalid !== 1'b1 && ++t < 99) @(posedge mclk);
    resp = bo.bresp;
    bi.bready <= 1'b0;
    if (t >= 99) n_fail++;
  endtask
  task automatic rc(input logic [2:0] i, input logic [7:0] e);
    int t;
    t = 0;
    @(posedge mclk);
    bi.araddr <= {hi, i, 2'b00};
    bi.arvalid <= 1'b1;
    bi.rready <= 1'b1;
    do @(posedge mclk); while (bo.arready !== 1'b1 && ++t < 99);
    bi.arvalid <= 1'b0;
    while (bo.rvalid !== 1'b1 && ++t < 99) @(posedge mclk);
    resp = bo.rresp;
    bi.rready <= 1'b0;
    if (t >= 99) n_fail++;
    chk(bo.rdata, {24'h000000, e});
  endtask
  function automatic logic [11:0] frame_of(input logic [7:0] fmt, input logic [7:0] d);
    int n;
    logic p;
    frame_of = 12'hFFF;
    frame_of[0] = 1'b0;
    n = 5 + int'(fmt[1:0]);
    p = ~fmt[LF_EVEN];
    for (int k = 0; k < n; k++)
    begin
      frame_of[k + 1] = d[k];
      p = p ^ d[k];
    end
    if (fmt[LF_PEN]) frame_of[n + 1] = fmt[LF_FORCE] ? ~fmt[LF_EVEN] : p;
  endfunction
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    bi = '0;
    bi.wstrb = 4'hF;
    hi = 7'h00;
    ring_n = 1'b1;
    rst_n = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    tick;
    chk(txi, 1'b1);
    rc(IDX_LINE, LINE_RESET);
    rc(IDX_MODEM, MODEM_RESET);
    chk({dtr_n, rts_n, ser_out}, 3'b111);
    wr(IDX_MODEM, 8'h03);
    tick;
    chk({dtr_n, rts_n}, 2'b00);
    wr(IDX_LINE, 8'h45);
    tick;
    chk(ser_out, 1'b0);
    repeat (60) @(posedge mclk);
    chk(ser_out, 1'b0);
    wr(IDX_LINE, 8'h05);
    tick;
    chk(ser_out, 1'b1);
    wr(IDX_SEVEN, 8'h5A);
    rc(IDX_SEVEN, 8'h5A);
    wr(IDX_MODEM, 8'h04);
    rc(IDX_SEVEN, 8'h10);
    chk({dtr_n, rts_n}, 2'b11);
    @(posedge mclk);
    ring_n <= 1'b0;
    tick;
    rc(IDX_MSTAT, 8'h40);
    @(posedge mclk);
    ring_n <= 1'b1;
    wr(IDX_MODEM, 8'h14);
    rc(IDX_MSTAT, 8'h40);
    rc(IDX_SEVEN, 8'h5A);
    chk({dtr_n, rts_n, ser_out}, 3'b111);
    wr(IDX_MODEM, 8'h00);
    rc(IDX_MSTAT, 8'h00);
    wr(IDX_LINE, LINE_KEY);
    wr(IDX_FIFO, 8'h10);
    rc(IDX_FIFO, 8'h10);
    wr(IDX_LINE, 8'h03);
    rc(IDX_FIFO, 8'h00);
    wr(IDX_MODEM, 8'h40);
    wr(IDX_SEVEN, 8'h33);
    rc(IDX_SEVEN, 8'h33);
    wr(IDX_MODEM, 8'h00);
    rc(IDX_SEVEN, 8'h5A);
    wr(IDX_LINE, 8'h83);
    rc(IDX_DATA, DIV_LOW_RESET);
    wr(IDX_LINE, 8'h03);
    hi = 7'h01;
    wr(IDX_LINE, 8'h00);
    chk(resp, RESP_DECERR);
    rc(IDX_LINE, 8'h00);
    chk(resp, RESP_DECERR);
    hi = 7'h00;
    rc(IDX_LINE, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      wr(IDX_LINE, fl[k]);
      fork
        u_serial_peer.grab(fr);
        wr(IDX_DATA, fd[k]);
      join
      chk(fr, frame_of(fl[k], fd[k]));
    end
    wr(IDX_LINE, 8'h07);
    fork
      u_serial_peer.grab(fr);
      begin
        wr(IDX_DATA, 8'h96);
        wr(IDX_DATA, 8'h69);
      end
    join
    chk(fr, {1'b0, 2'b11, 8'h96, 1'b0});
    wr(IDX_LINE, 8'h03);
    wr(IDX_FIFO, 8'h01);
    repeat (8) u_serial_peer.send(8'h3C);
    tick;
    chk({rxq, rxi}, 2'b00);
    u_serial_peer.send(8'hC3);
    tick;
    chk(rxi, 1'b1);
    rc(IDX_DATA, 8'h3C);
    tick;
    chk(rxi, 1'b0);
    wr(IDX_FIFO, 8'h03);
    tick;
    chk({rxq, rxi}, 2'b10);
    rc(IDX_DATA, 8'h00);
    rc(IDX_FIFO, 8'hC0);
    wr(IDX_LINE, 8'h83);
    wr(IDX_DATA, 8'h00);
    wr(IDX_LINE, 8'h03);
    for (int k = 0; k < 9; k++)
    begin
      wr(IDX_DATA, 8'hAA);
      if (k == 2)
      begin
        tick;
        chk({txq, txi}, 2'b11);
        wr(IDX_FIFO, 8'h39);
        tick;
        chk({txq, txi}, 2'b01);
      end
    end
    tick;
    chk({txq, txi}, 2'b10);
    wr(IDX_FIFO, 8'h3D);
    tick;
    chk({txq, txi}, 2'b01);
    wr(IDX_FIFO, 8'h08);
    rc(IDX_FIFO, 8'h00);
    tally_and_finish;
  end
endmodule // tb_top
